// ### dv/core_model.sv
`timescale 1ns/1ps
module core_model
    import sleep_wakeup_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_run,
    input wire logic halt_cmd,
    input wire logic master_clear_pin_cmd,
    input wire logic [PC_W-1:0] pc_in,
    output logic halt_exec,
    output logic [PC_W-1:0] core_pc,
    output logic master_clear_pin_n,
    output pins_s core_pins
);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            halt_exec <= 1'b0;
            core_pc <= '0;
            master_clear_pin_n <= 1'b1;
            core_pins <= '0;
        end
        else
        begin
            // A stopped core cannot issue a halt
            halt_exec <= halt_cmd & core_run;
            // word after halt is a no-op slot
            core_pc <= pc_in;
            // pin stays high unless a reset is asked
            master_clear_pin_n <= ~master_clear_pin_cmd;
            // Port logic keeps moving so a leaky pin hold shows
            core_pins <= pins_s'(core_pins + 16'h1357);
        end
    end
endmodule : core_model

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench
    import sleep_wakeup_pkg::*;
;
    localparam int WDT_CYC = 64;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, halt_exec, other_irq = 0;
    logic halt_cmd = 0, master_clear_pin_cmd = 0, master_clear_pin_n;
    logic [PC_W-1:0] core_pc, pc_in = '0, prefetch_addr, vector_addr;
    logic [SRC_N-1:0] irq_src = '0;
    pins_s core_pins, pin_drive;
    logic core_reset_n, core_run, sys_clk_en, osc_driver_en, sec_osc_en;
    logic prefetch_req, vector_req, irq_pending;
    logic [6:0] ctrl_sh = '0;
    logic [6:0] qual [7] = '{7'h04, 7'h08, 7'h10, 7'h00, 7'h00, 7'h00, 7'h20};
    int bad_count = 0, checks = 0, cyc = 0, waited = 0;

    sleep_wakeup_controller #(.WDT_CYCLES(WDT_CYC)) i_sleep_wakeup_controller
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
        .core_pc(core_pc), .irq_src(irq_src), .other_irq(other_irq),
        .master_clear_pin_n(master_clear_pin_n), .core_pins(core_pins),
        .pin_drive(pin_drive), .core_reset_n(core_reset_n),
        .core_run(core_run), .sys_clk_en(sys_clk_en),
        .osc_driver_en(osc_driver_en), .sec_osc_en(sec_osc_en),
        .prefetch_req(prefetch_req), .prefetch_addr(prefetch_addr),
        .vector_req(vector_req), .vector_addr(vector_addr),
        .irq_pending(irq_pending)
    );
    core_model i_core_model
    (
        .pclk(pclk), .presetn(presetn), .core_run(core_run),
        .halt_cmd(halt_cmd), .master_clear_pin_cmd(master_clear_pin_cmd), .pc_in(pc_in),
        .halt_exec(halt_exec), .core_pc(core_pc),
        .master_clear_pin_n(master_clear_pin_n), .core_pins(core_pins)
    );

    always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

    task summarize;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // Generous ceiling; the whole run needs under a thousand cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            $display("mismatch timeout expected done seen hang");
            summarize();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Entered just after an edge; leaves one idle edge before returning
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the slave
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr_ctrl(input logic [6:0] v);
        ctrl_sh = v;
        apb(1'b1, CTRL_OFS, {25'h0, v});
    endtask : wr_ctrl

    task wait_run(input logic lvl, input int lim);
        waited = 0;
        do
        begin
            @(posedge pclk);
            waited++;
        end
        while (core_run !== lvl && waited < lim);
        chk("core_run", lvl, core_run);
    endtask : wait_run

    task do_halt(input logic [PC_W-1:0] pc, input logic full);
        logic [15:0] held;
        pc_in <= pc;
        halt_cmd <= 1'b1;
        @(posedge pclk);
        halt_cmd <= 1'b0;
        wait_run(1'b0, 10);
        chk("prefetch_req", 1'b1, prefetch_req);
        chk("prefetch_addr", 13'(pc + 13'h0001), prefetch_addr);
        if (full)
        begin
            repeat (2) @(posedge pclk);
            chk("osc_driver_en", 1'b0, osc_driver_en);
            chk("sys_clk_en", 1'b0, sys_clk_en);
            chk("sec_osc_en", ctrl_sh[6], sec_osc_en);
            held = pin_drive;
            repeat (5) @(posedge pclk);
            chk("pin_drive", held, pin_drive);
            apb(1'b0, STATUS_OFS, '0);
            chk("status_flags", 3'b110, rd[2:0]);
        end
    endtask : do_halt

    task t_regs;
        apb(1'b0, STATUS_OFS, '0);
        chk("status", 32'h3, rd);
        apb(1'b1, CTRL_OFS, 32'hffffffff);
        apb(1'b0, CTRL_OFS, '0);
        chk("ctrl", 32'h7f, rd);
        wr_ctrl(7'h00);
        apb(1'b0, 12'h010, '0);
        chk("unmapped_err", 1'b1, er);
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, STATUS_OFS, 32'h0);
        apb(1'b0, STATUS_OFS, '0);
        chk("status_ro", 32'h3, rd);
        chk("status_ro_err", 1'b0, er);
    endtask : t_regs

    // Odd sources run with the global enable set, even ones without
    task t_irq(input int s);
        wr_ctrl(qual[s] | 7'h40 | (s % 2 == 1 ? 7'h02 : 7'h00));
        apb(1'b1, IRQ_EN_OFS, 32'h1 << s);
        do_halt(13'h1ff8 + 13'(s), 1'b1);
        irq_src[s] <= 1'b1;
        wait_run(1'b1, 60);
        chk("sys_clk_en", 1'b1, sys_clk_en);
        chk("osc_driver_en", 1'b1, osc_driver_en);
        irq_src <= '0;
        @(posedge pclk);
        chk("vector_req", ctrl_sh[1], vector_req);
        chk("vector_addr", 13'h0004, vector_addr);
        apb(1'b0, STATUS_OFS, '0);
        chk("cause", CAUSE_IRQ, rd[4:3]);
    endtask : t_irq

    task t_pending;
        wr_ctrl(7'h00);
        apb(1'b1, IRQ_EN_OFS, 32'h08);
        irq_src[3] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("irq_pending", 1'b1, irq_pending);
        apb(1'b0, FLAGS_OFS, '0);
        chk("flags", 32'h08, rd);
        // Halt at the top word so the prefetch address wraps to zero
        do_halt(13'h1fff, 1'b0);
        wait_run(1'b1, 30);
        irq_src <= '0;
        @(posedge pclk);
        chk("vector_req", 1'b0, vector_req);
    endtask : t_pending

    task t_block;
        wr_ctrl(7'h02);
        apb(1'b1, IRQ_EN_OFS, 32'h01);
        do_halt(13'h0200, 1'b1);
        irq_src <= 7'h7f;
        other_irq <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("core_run", 1'b0, core_run);
        chk("irq_pending", 1'b0, irq_pending);
        master_clear_pin_cmd <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("core_reset_n", 1'b0, core_reset_n);
        irq_src <= '0;
        other_irq <= 1'b0;
        master_clear_pin_cmd <= 1'b0;
        wait_run(1'b1, 20);
        chk("core_reset_n", 1'b1, core_reset_n);
        apb(1'b0, STATUS_OFS, '0);
        chk("cause", CAUSE_RESET, rd[4:3]);
    endtask : t_block

    task t_wdt;
        int lows;
        wr_ctrl(7'h01);
        apb(1'b1, IRQ_EN_OFS, 32'h0);
        repeat (40) @(posedge pclk);
        do_halt(13'h0300, 1'b1);
        wait_run(1'b1, 200);
        chk("wdt_cleared_entry", 1'b1, waited > 40);
        apb(1'b0, STATUS_OFS, '0);
        chk("status", 32'h10, rd[4:0]);
        // Late interrupt wake: without a clear the old count would expire
        apb(1'b1, IRQ_EN_OFS, 32'h08);
        do_halt(13'h0310, 1'b0);
        repeat (30) @(posedge pclk);
        irq_src[3] <= 1'b1;
        wait_run(1'b1, 30);
        irq_src <= '0;
        lows = 0;
        repeat (40)
        begin
            @(posedge pclk);
            if (core_reset_n !== 1'b1)
                lows++;
        end
        chk("reset_lows", 32'h0, lows);
        wr_ctrl(7'h00);
    endtask : t_wdt

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        for (int s = 0; s < SRC_N; s++)
            t_irq(s);
        t_pending();
        t_block();
        t_wdt();
        summarize();
    end
endmodule : testbench

// ### hdl/sleep_wakeup_controller.sv
// Summary of operation
// - Executing the halt instruction enters the halt state.
// - Halt entry with watchdog enabled clears its count; it keeps running.
// - Halt entry clears power-down flag and sets timeout flag.
// - Main oscillator driver off while halted; secondary oscillator untouched.
// - I/O pins keep their pre-halt level and drive while halted.
// - Watchdog timeout reset never drives the master clear pin low.
// - Wake on master clear reset, watchdog wake, or interrupt.
// - Master clear wake fully resets; other wakes continue execution.
// - Power-down flag set at power-up; timeout flag cleared by watchdog wake.
// - Only the seven listed qualified peripheral sources can wake.
// - Other peripherals raise no interrupt while halted.
// - Halt instruction prefetches the instruction at pc plus one.
// - Interrupt wakes need the source enable, never the global enable.
// - Global enable clear: resume after the halt instruction.
// - Global enable set: run next instruction, then branch to vector.
// - Source pending at halt: finish instruction, wake at once.
// - Interrupt and watchdog wakes clear the watchdog count; master clear does not.
`timescale 1ns/1ps
module sleep_wakeup_controller
    import sleep_wakeup_pkg::*;
#(
    parameter int unsigned WDT_CYCLES = WDT_PERIOD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_exec,
    input wire logic [PC_W-1:0] core_pc,
    input wire logic [SRC_N-1:0] irq_src,
    input wire logic other_irq,
    input wire logic master_clear_pin_n,
    input wire pins_s core_pins,
    output pins_s pin_drive,
    output logic core_reset_n,
    output logic core_run,
    output logic sys_clk_en,
    output logic osc_driver_en,
    output logic sec_osc_en,
    output logic prefetch_req,
    output logic [PC_W-1:0] prefetch_addr,
    output logic vector_req,
    output logic [PC_W-1:0] vector_addr,
    output logic irq_pending
);
    ctrl_s ctrl;
    ctrl_s next_ctrl;
    logic [SRC_N-1:0] irq_en;
    logic [SRC_N-1:0] next_irq_en;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [SRC_N-1:0] src_sync;
    logic master_clear_pin_sync;
    logic master_clear_pin_asserted;
    logic wdt_timeout;
    logic [SRC_N-1:0] src_qual;
    logic [SRC_N-1:0] wake_src;
    logic wake_irq;
    status_s status;
    phase_e phase;
    phase_e next_phase;
    logic pd;
    logic next_pd;
    logic to;
    logic next_to;
    logic [1:0] cause;
    logic [1:0] next_cause;
    logic wdt_clr;
    logic next_wdt_clr;
    logic [RESTART_CNT_W-1:0] cnt;
    logic [RESTART_CNT_W-1:0] next_cnt;
    logic pin_hold;
    logic next_pin_hold;
    pins_s next_pin_drive;
    logic next_core_reset_n;
    logic next_core_run;
    logic next_sys_clk_en;
    logic next_osc;
    logic next_prefetch_req;
    logic [PC_W-1:0] next_prefetch_addr;
    logic next_vector_req;
    logic next_irq_pending;

    sync3 #(.W(SRC_N), .INIT(7'h00)) u_src_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(irq_src),
        .q(src_sync)
    );

    sync3 #(.W(1), .INIT(1'b1)) u_master_clear_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(master_clear_pin_n),
        .q(master_clear_pin_sync)
    );

    // Count cleared on halt entry and on interrupt or watchdog wake; held at zero while wdt_en is clear, runs on otherwise
    watchdog_counter #(.PERIOD(WDT_CYCLES)) u_wdt (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl.wdt_en),
        .clear(wdt_clr),
        .timeout(wdt_timeout)
    );

    assign master_clear_pin_asserted = ~master_clear_pin_sync;
    assign status = '{cause: cause, halted: (phase == st_halted),
                      timeout_flag: to, power_down_flag: pd};

    always_comb
    begin
        src_qual = {SRC_N{1'b1}};
        src_qual[SRC_SEC_TIMER] = ctrl.t1_async;
        src_qual[SRC_SERIAL_RX] = ctrl.rx_slave;
        src_qual[SRC_ADC] = ctrl.adc_rc;
        src_qual[SRC_SYNC_SERIAL] = ctrl.ssp_slave;
    end

    // source enable only, global enable ignored
    assign wake_src = src_sync & irq_en & src_qual;
    assign wake_irq = |wake_src;

    // APB slave: no wait states, read data captured in setup cycle
    always_comb
    begin
        next_ctrl = ctrl;
        next_irq_en = irq_en;
        next_prdata = prdata;
        next_pslverr = pslverr;
        next_pready = psel && !penable;
        if (psel && !penable)
        begin
            next_pslverr = 1'b0;
            unique case (paddr)
                CTRL_OFS: next_prdata = 32'(ctrl);
                IRQ_EN_OFS: next_prdata = 32'(irq_en);
                STATUS_OFS: next_prdata = 32'(status);
                FLAGS_OFS: next_prdata = 32'(src_sync);
                default:
                begin
                    next_prdata = 32'h0;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pready && pwrite && !pslverr)
        begin
            if (paddr == CTRL_OFS)
                next_ctrl = ctrl_s'(pwdata[6:0]);
            if (paddr == IRQ_EN_OFS)
                next_irq_en = pwdata[SRC_N-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CTRL_RST;
            irq_en <= IRQ_EN_RST;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            irq_en <= next_irq_en;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Sleep sequencer
    always_comb
    begin
        next_phase = phase;
        next_pd = pd;
        next_to = to;
        next_cause = cause;
        next_cnt = cnt;
        next_wdt_clr = 1'b0;
        next_core_reset_n = 1'b1;
        next_core_run = core_run;
        next_sys_clk_en = sys_clk_en;
        next_osc = osc_driver_en;
        next_pin_hold = pin_hold;
        next_prefetch_req = 1'b0;
        next_prefetch_addr = prefetch_addr;
        next_vector_req = 1'b0;
        next_pin_drive = pin_hold ? pin_drive : core_pins;
        next_irq_pending = (phase == st_run) &&
                           (|(src_sync & irq_en) || other_irq);
        if (master_clear_pin_asserted)
        begin
            // master clear: full reset, flags kept for software
            next_phase = st_resume;
            next_cause = CAUSE_RESET;
            next_core_reset_n = 1'b0;
            next_core_run = 1'b0;
            next_sys_clk_en = 1'b1;
            next_osc = 1'b1;
            next_pin_hold = 1'b0;
            next_cnt = '0;
        end
        else
        begin
            unique case (phase)
                st_run:
                begin
                    if (wdt_timeout)
                    begin
                        // reset stays internal, pin is input only
                        next_core_reset_n = 1'b0;
                        next_to = 1'b0;
                        next_cause = CAUSE_WDT;
                    end
                    else if (halt_exec)
                    begin
                        next_phase = st_halt_entry;
                        next_core_run = 1'b0;
                        next_pd = 1'b0;
                        next_to = 1'b1;
                        next_wdt_clr = ctrl.wdt_en;
                        next_prefetch_req = 1'b1;
                        next_prefetch_addr = core_pc + PREFETCH_STEP;
                    end
                end
                st_halt_entry:
                begin
                    if (wake_irq)
                    begin
                        next_phase = st_clk_restart;
                        next_cause = CAUSE_IRQ;
                        next_wdt_clr = 1'b1;
                        next_cnt = '0;
                    end
                    else
                    begin
                        next_phase = st_halted;
                        next_osc = 1'b0;
                        next_sys_clk_en = 1'b0;
                        next_pin_hold = 1'b1;
                    end
                end
                st_halted:
                begin
                    if (wdt_timeout || wake_irq)
                    begin
                        next_phase = st_clk_restart;
                        next_to = wdt_timeout ? 1'b0 : to;
                        next_cause = wdt_timeout ? CAUSE_WDT : CAUSE_IRQ;
                        next_wdt_clr = 1'b1;
                        next_osc = 1'b1;
                        next_sys_clk_en = 1'b1;
                        next_cnt = '0;
                    end
                end
                st_clk_restart:
                begin
                    next_osc = 1'b1;
                    next_sys_clk_en = 1'b1;
                    next_cnt = cnt + 4'h1;
                    if (cnt == RESTART_CNT_W'(OSC_START_CYC - 1))
                    begin
                        next_phase = st_resume;
                        next_pin_hold = 1'b0;
                    end
                end
                st_resume:
                begin
                    next_core_run = 1'b1;
                    next_phase = (ctrl.global_irq_enable && cause == CAUSE_IRQ) ?
                                 st_vector : st_run;
                end
                st_vector:
                begin
                    next_vector_req = 1'b1;
                    next_phase = st_run;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= st_run;
            pd <= PD_RST;
            to <= TO_RST;
            cause <= CAUSE_NONE;
            cnt <= '0;
            wdt_clr <= 1'b0;
            core_reset_n <= 1'b0;
            core_run <= 1'b1;
            sys_clk_en <= 1'b1;
            osc_driver_en <= 1'b1;
            sec_osc_en <= 1'b0;
            pin_hold <= 1'b0;
            pin_drive <= '0;
            prefetch_req <= 1'b0;
            prefetch_addr <= '0;
            vector_req <= 1'b0;
            vector_addr <= IRQ_VECTOR;
            irq_pending <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            pd <= next_pd;
            to <= next_to;
            cause <= next_cause;
            cnt <= next_cnt;
            wdt_clr <= next_wdt_clr;
            core_reset_n <= next_core_reset_n;
            core_run <= next_core_run;
            sys_clk_en <= next_sys_clk_en;
            osc_driver_en <= next_osc;
            sec_osc_en <= ctrl.sec_osc;
            pin_hold <= next_pin_hold;
            pin_drive <= next_pin_drive;
            prefetch_req <= next_prefetch_req;
            prefetch_addr <= next_prefetch_addr;
            vector_req <= next_vector_req;
            vector_addr <= IRQ_VECTOR;
            irq_pending <= next_irq_pending;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence halt_taken;
        phase == st_run && halt_exec && !master_clear_pin_asserted && !wdt_timeout;
    endsequence

    sequence wake_from_halt;
        phase == st_halted && !master_clear_pin_asserted && (wdt_timeout || wake_irq);
    endsequence

    halt_entry_a: assert property (halt_taken |=>
        phase == st_halt_entry && !core_run)
        else $error("halt not entered");
    entry_flags_a: assert property (halt_taken |=> !pd && to)
        else $error("entry flags wrong");
    entry_wdt_a: assert property ((halt_taken and ctrl.wdt_en) |=>
        wdt_clr ##1 (!wdt_clr || phase == st_clk_restart))
        else $error("watchdog not cleared on entry");
    prefetch_a: assert property (halt_taken |=> prefetch_req &&
        prefetch_addr == $past(core_pc) + PREFETCH_STEP)
        else $error("prefetch address wrong");
    osc_off_a: assert property (phase == st_halted |->
        !osc_driver_en && !sys_clk_en && sec_osc_en == $past(ctrl.sec_osc))
        else $error("oscillator state wrong in halt");
    pins_hold_a: assert property (phase == st_halted &&
        $past(phase) == st_halted |-> $stable(pin_drive))
        else $error("pins moved in halt");
    wake_clear_a: assert property (wake_from_halt |=>
        wdt_clr && phase == st_clk_restart)
        else $error("wake did not clear watchdog");
    wdt_wake_a: assert property (wake_from_halt and wdt_timeout |=>
        !to && cause == CAUSE_WDT)
        else $error("watchdog wake flag wrong");
    master_clear_pin_reset_a: assert property (master_clear_pin_asserted |=>
        !core_reset_n && !core_run)
        else $error("master clear did not reset");
    immediate_wake_a: assert property (phase == st_halt_entry &&
        wake_irq && !master_clear_pin_asserted |=> phase == st_clk_restart)
        else $error("pending source did not wake");
    restart_a: assert property (wake_from_halt |=>
        (sys_clk_en && !core_run)[*8])
        else $error("clock restart too short");
    vector_a: assert property (phase == st_resume && ctrl.global_irq_enable &&
        cause == CAUSE_IRQ && !master_clear_pin_asserted |=> ##1 vector_req)
        else $error("no vector branch");
    no_vector_a: assert property (phase == st_resume &&
        !ctrl.global_irq_enable && !master_clear_pin_asserted |=> core_run ##1 !vector_req)
        else $error("unexpected vector branch");
    silent_halt_a: assert property (phase != st_run |=>
        !irq_pending)
        else $error("interrupt raised in halt");
endmodule : sleep_wakeup_controller

// ### hdl/sleep_wakeup_pkg.sv
package sleep_wakeup_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int OSC_START_NS = 64;
    localparam int OSC_START_CYC =
        (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDT_PERIOD_US = 100;
    localparam int WDT_PERIOD_CYC = (WDT_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int RESTART_CNT_W = 4;

    // Program counter
    localparam int PC_W = 13;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam logic [PC_W-1:0] PREFETCH_STEP = 13'h0001;

    // Wake sources
    localparam int SRC_N = 7;
    localparam int SRC_SEC_TIMER = 0;
    localparam int SRC_SERIAL_RX = 1;
    localparam int SRC_ADC = 2;
    localparam int SRC_CHANGE = 3;
    localparam int SRC_EXT_PIN = 4;
    localparam int SRC_CAPTURE = 5;
    localparam int SRC_SYNC_SERIAL = 6;
    localparam int PIN_N = 8;

    // Register map
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] IRQ_EN_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;
    localparam logic [11:0] FLAGS_OFS = 12'h00c;

    // Wake cause codes
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_IRQ = 2'h1;
    localparam logic [1:0] CAUSE_WDT = 2'h2;
    localparam logic [1:0] CAUSE_RESET = 2'h3;

    typedef struct packed {
        logic sec_osc;
        logic ssp_slave;
        logic adc_rc;
        logic rx_slave;
        logic t1_async;
        logic global_irq_enable;
        logic wdt_en;
    } ctrl_s;

    typedef struct packed {
        logic [1:0] cause;
        logic halted;
        logic timeout_flag;
        logic power_down_flag;
    } status_s;

    typedef struct packed {
        logic [PIN_N-1:0] out;
        logic [PIN_N-1:0] oe;
    } pins_s;

    // Reset values
    localparam ctrl_s CTRL_RST = 7'h00;
    localparam logic [SRC_N-1:0] IRQ_EN_RST = 7'h00;
    localparam logic PD_RST = 1'b1;
    localparam logic TO_RST = 1'b1;

    typedef enum {
        st_run,
        st_halt_entry,
        st_halted,
        st_clk_restart,
        st_resume,
        st_vector
    } phase_e;
endpackage : sleep_wakeup_pkg

// ### hdl/sync3.sv
`timescale 1ns/1ps
module sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // A bit moves only once the last two stages agree
    always_comb
    begin
        next_q = (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q <= INIT;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end
endmodule : sync3

// ### hdl/watchdog_counter.sv
`timescale 1ns/1ps
module watchdog_counter #(
    parameter int unsigned PERIOD = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic clear,
    output logic timeout
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_timeout;

    always_comb
    begin
        next_count = count;
        next_timeout = 1'b0;
        if (!enable || clear)
        begin
            next_count = 32'h0;
        end
        else if (count == 32'(PERIOD - 1))
        begin
            next_count = 32'h0;
            next_timeout = 1'b1;
        end
        else
        begin
            next_count = count + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 32'h0;
            timeout <= 1'b0;
        end
        else
        begin
            count <= next_count;
            timeout <= next_timeout;
        end
    end
endmodule : watchdog_counter
